// *** design/chan_func_ctrl.sv ***
// chan_func_ctrl: one converter channel's output code sequencer with its
// function setup register. assumes the host's write strobes, load_strobe and
// margin commands are synchronous single-cycle pulses, margin_high >= margin_low.
`timescale 1ns/1ps
`default_nettype none
module chan_func_ctrl #(
  parameter int P_C11 = chan_fn_pkg::CYC[11],
  parameter int P_C12 = chan_fn_pkg::CYC[12],
  parameter int P_C13 = chan_fn_pkg::CYC[13],
  parameter int P_C14 = chan_fn_pkg::CYC[14],
  parameter int P_C15 = chan_fn_pkg::CYC[15]
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_setup_wr,
  input  wire logic        i_code_wr,
  input  wire logic        i_bcast_wr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_load_strobe,
  input  wire logic        i_load_trig,
  input  wire logic        i_clear,
  input  wire logic [11:0] i_margin_high,
  input  wire logic [11:0] i_margin_low,
  input  wire logic        i_go_high,
  input  wire logic        i_go_low,
  input  wire logic        i_wave_en,
  output var  logic [15:0] o_setup_q,
  output var  logic [11:0] o_code_q,
  output var  logic        o_slewing
);
  typedef enum logic [1:0] {ST_HOLD, ST_SLEW, ST_WAVE} mode_e;
  mode_e       state_q;
  logic [11:0] pend_q;
  logic [11:0] target_q;
  logic [15:0] phase_q;
  logic        up_q;
  logic        strobe_q;
  logic        tick;

  ////////////////////////////////////////////////////////////////////////////
  // decoded setup fields
  logic        clr_mid, defer, bcast_ok, log_mode;
  logic [1:0]  ph_sel;
  logic [2:0]  wave_sel;
  logic [5:0]  step_lin;
  logic [3:0]  rate_lin;
  logic [3:0]  t_idx;
  assign clr_mid  = o_setup_q[chan_fn_pkg::CLR_BIT];
  assign defer    = o_setup_q[chan_fn_pkg::DEFER_BIT];
  assign bcast_ok = o_setup_q[chan_fn_pkg::BCAST_BIT];
  assign ph_sel   = o_setup_q[chan_fn_pkg::PH_HI:chan_fn_pkg::PH_LO];
  assign wave_sel = o_setup_q[chan_fn_pkg::WAVE_HI:chan_fn_pkg::WAVE_LO];
  assign log_mode = o_setup_q[chan_fn_pkg::LOG_BIT];
  assign step_lin = chan_fn_pkg::STEP_LSB[o_setup_q[chan_fn_pkg::STEP_HI:chan_fn_pkg::STEP_LO]];
  assign rate_lin = o_setup_q[chan_fn_pkg::RATE_HI:chan_fn_pkg::RATE_LO];

  // log intervals map onto odd entries of the linear table
  always_comb
  begin
    if (state_q == ST_WAVE || !log_mode)
      t_idx = rate_lin;
    else if (up_q)
      t_idx = {o_setup_q[chan_fn_pkg::STEP_HI:chan_fn_pkg::STEP_LO], 1'b1};
    else
      t_idx = {o_setup_q[chan_fn_pkg::FALL_HI:chan_fn_pkg::FALL_LO], 1'b1};
  end

  step_timer #(
    .P_C11 (P_C11),
    .P_C12 (P_C12),
    .P_C13 (P_C13),
    .P_C14 (P_C14),
    .P_C15 (P_C15)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_run      (state_q != ST_HOLD),
    .i_idx      (t_idx),
    .o_tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write acceptance and load events
  logic        wr_ok, load_ev, wave_ok;
  logic [11:0] wcode;
  assign wr_ok   = i_code_wr || (i_bcast_wr && bcast_ok);
  assign wcode   = i_wdata[chan_fn_pkg::DATA_HI:chan_fn_pkg::DATA_LO];
  assign load_ev = (strobe_q && !i_load_strobe) || i_load_trig;
  assign wave_ok = i_wave_en && rate_lin != chan_fn_pkg::RATE_JUMP && (wave_sel == chan_fn_pkg::WAVE_TRI ||
    wave_sel == chan_fn_pkg::WAVE_SAW || wave_sel == chan_fn_pkg::WAVE_ISAW ||
    wave_sel == chan_fn_pkg::WAVE_SINE);

  ////////////////////////////////////////////////////////////////////////////
  // slew step: linear fixed, log proportional to the code
  logic [11:0] lstep, step, gap, slew_d;
  assign lstep = (o_code_q >> chan_fn_pkg::LOG_SHIFT) == chan_fn_pkg::CODE_ZERO ? chan_fn_pkg::CODE_ONE
    : o_code_q >> chan_fn_pkg::LOG_SHIFT;
  assign step  = log_mode ? lstep : {6'h00, step_lin};
  assign gap   = up_q ? target_q - o_code_q : o_code_q - target_q;
  assign slew_d = gap <= step ? target_q : (up_q ? o_code_q + step : o_code_q - step);

  ////////////////////////////////////////////////////////////////////////////
  // waveform shaping across the margin span
  logic [11:0] ph, wave, span, half;
  logic [21:0] sq;
  logic [23:0] prod;
  assign ph   = phase_q[chan_fn_pkg::PH_W-1:chan_fn_pkg::DATA_LO];
  assign sq   = {11'h000, ph[10:0]} * {11'h000, ~ph[10:0]};
  assign half = {1'b0, sq[19:9]};
  always_comb
  begin
    case (wave_sel)
      chan_fn_pkg::WAVE_SAW:  wave = ph;
      chan_fn_pkg::WAVE_ISAW: wave = ~ph;
      chan_fn_pkg::WAVE_SINE: wave = ph[11] ? chan_fn_pkg::CODE_MID - half : chan_fn_pkg::CODE_MID + half;
      default:                wave = ph[11] ? ~{ph[10:0], 1'b0} : {ph[10:0], 1'b0};
    endcase
  end
  assign span = i_margin_high - i_margin_low;
  assign prod = {12'h000, span} * {12'h000, wave};

  ////////////////////////////////////////////////////////////////////////////
  // setup register and load_strobe history
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_setup_q <= chan_fn_pkg::SETUP_RST;
      strobe_q  <= 1'b1;
    end
    else
    begin
      if (i_setup_wr)
        o_setup_q <= i_wdata;
      strobe_q <= i_load_strobe;
    end
  end

  // held code for deferred update
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pend_q <= chan_fn_pkg::CODE_ZERO;
    else if (wr_ok && defer)
      pend_q <= wcode;
  end

  // output code sequencer, clear first, then writes, loads, margin moves
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q  <= ST_HOLD;
      o_code_q <= chan_fn_pkg::CODE_ZERO;
      target_q <= chan_fn_pkg::CODE_ZERO;
      phase_q  <= '0;
      up_q     <= 1'b0;
    end
    else if (i_clear)
    begin
      state_q  <= ST_HOLD;
      o_code_q <= clr_mid ? chan_fn_pkg::CODE_MID : chan_fn_pkg::CODE_ZERO;
    end
    else if (wr_ok && !defer)
    begin
      state_q  <= ST_HOLD;
      o_code_q <= wcode;
    end
    else if (load_ev && defer)
    begin
      state_q  <= ST_HOLD;
      o_code_q <= pend_q;
    end
    else if (i_go_high || i_go_low)
    begin
      target_q <= i_go_high ? i_margin_high : i_margin_low;
      up_q     <= (i_go_high ? i_margin_high : i_margin_low) > o_code_q; // direction from the chosen bound
      if (!log_mode && rate_lin == chan_fn_pkg::RATE_JUMP)
      begin
        state_q  <= ST_HOLD;
        o_code_q <= i_go_high ? i_margin_high : i_margin_low;
      end
      else
      begin
        state_q <= ST_SLEW;
        if (log_mode && o_code_q == chan_fn_pkg::CODE_ZERO && i_margin_low == chan_fn_pkg::CODE_ZERO)
          o_code_q <= chan_fn_pkg::CODE_ONE;
      end
    end
    else
    begin
      case (state_q)
        ST_HOLD:
          if (wave_ok)
          begin
            state_q <= ST_WAVE;
            phase_q <= chan_fn_pkg::PH_OFS[ph_sel];
          end
        ST_SLEW:
          if (o_code_q == target_q)
            state_q <= ST_HOLD;
          else if (tick)
            o_code_q <= slew_d;
        ST_WAVE:
          if (!wave_ok)
            state_q <= ST_HOLD;
          else if (tick)
          begin
            phase_q  <= phase_q + {6'h00, step_lin, 4'h0};
            o_code_q <= i_margin_low + prod[23:12];
          end
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // busy flag
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_slewing <= 1'b0;
    else
      o_slewing <= state_q == ST_SLEW;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic quiet;
  assign quiet = !i_clear && !wr_ok && !load_ev && !i_go_high && !i_go_low;

  property p_clear_level;
    i_clear |=> o_code_q == ($past(clr_mid) ? chan_fn_pkg::CODE_MID : chan_fn_pkg::CODE_ZERO);
  endproperty
  a_clear_level: assert property (p_clear_level) else $error("clear level wrong");
  property p_write_now;
    !i_clear && wr_ok && !defer |=> o_code_q == $past(wcode);
  endproperty
  a_write_now: assert property (p_write_now) else $error("immediate write lost");
  property p_defer_hold;
    state_q == ST_HOLD && !wave_ok && defer && !i_clear && !load_ev && !i_go_high && !i_go_low
      |=> $stable(o_code_q);
  endproperty
  a_defer_hold: assert property (p_defer_hold) else $error("deferred code leaked");
  property p_load;
    !i_clear && !wr_ok && defer && strobe_q && !i_load_strobe |=> o_code_q == $past(pend_q);
  endproperty
  a_load: assert property (p_load) else $error("load edge ignored");
  property p_bcast_off;
    state_q == ST_HOLD && !wave_ok && !i_clear && !i_code_wr && !load_ev && !i_go_high && !i_go_low && !bcast_ok
      |=> $stable(o_code_q);
  endproperty
  a_bcast_off: assert property (p_bcast_off) else $error("broadcast taken while refused");
  property p_jump;
    !i_clear && !wr_ok && !load_ev && (i_go_high || i_go_low) && !log_mode && rate_lin == chan_fn_pkg::RATE_JUMP
      |=> o_code_q == ($past(i_go_high) ? $past(i_margin_high) : $past(i_margin_low)) && state_q == ST_HOLD;
  endproperty
  a_jump: assert property (p_jump) else $error("zero interval did not jump");
  property p_log_one;
    !i_clear && !wr_ok && !load_ev && i_go_high && log_mode && o_code_q == chan_fn_pkg::CODE_ZERO
      && i_margin_low == chan_fn_pkg::CODE_ZERO |=> o_code_q == chan_fn_pkg::CODE_ONE;
  endproperty
  a_log_one: assert property (p_log_one) else $error("log slew not started at one");
  property p_no_overshoot;
    state_q == ST_SLEW && up_q && o_code_q <= target_q && quiet |=> o_code_q <= target_q;
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("slew overshoot");
  property p_lin_step;
    state_q == ST_SLEW && !log_mode && tick && quiet && o_code_q != target_q
      |=> (up_q ? o_code_q - $past(o_code_q) : $past(o_code_q) - o_code_q) <= {6'h00, $past(step_lin)};
  endproperty
  a_lin_step: assert property (p_lin_step) else $error("linear step too large");
  property p_phase;
    state_q == ST_HOLD && wave_ok && quiet |=> state_q == ST_WAVE && phase_q == chan_fn_pkg::PH_OFS[$past(ph_sel)];
  endproperty
  a_phase: assert property (p_phase) else $error("phase offset wrong");
  c_slew_done: cover property (state_q == ST_SLEW ##[1:1000] state_q == ST_HOLD);
  c_wave_run: cover property (state_q == ST_WAVE && tick);
  c_load_edge: cover property (defer && strobe_q && !i_load_strobe);
  c_bcast_ok: cover property (i_bcast_wr && bcast_ok);
endmodule
`default_nettype wire

// *** design/chan_fn_pkg.sv ***
// chan_fn_pkg: field layout, codes, step and interval tables for the channel
// function setup logic; assumes a 10 MHz core clock.
// How it works
// - a clear sets the code to zero-scale, or mid-scale if clear_level_select is 1.
// - with deferral off, a written code reaches the output right after the write.
// - with deferral on, the code waits for a load_strobe fall or the load trigger.
// - broadcast writes update the channel only while broadcast_accept is 1.
// - bit 7 picks linear or logarithmic slew and the meaning of bits 6:0.
// - linear step field 6:4 gives 1, 2, 3, 4, 6, 8, 16 or 32 LSB.
// - linear interval code 0000 makes margin moves jump and keeps waves from running.
// - linear interval field 3:0 gives 4 us to 5127.92 us per step.
// - logarithmic slew walks between the two bound codes in 3.125 percent steps.
// - rising logarithmic steps grow by a factor of 1.03125.
// - falling logarithmic steps shrink by a factor of 0.96875.
// - a logarithmic slew from code zero with a zero lower bound starts from code 1.
// - logarithmic rise interval field 6:4 uses the odd entries of the interval table.
// - logarithmic fall interval field 3:1 uses the same table; bit 0 is ignored.
// - logarithmic steps are timed by rise going up, fall going down.
// - the output code is straight binary, left-aligned at bit 15, low bits ignored.
`default_nettype none
package chan_fn_pkg;
  localparam int CODE_W    = 12;
  localparam int REG_W     = 16;
  localparam int CNT_W     = 16;
  localparam int CLR_BIT   = 15;
  localparam int DEFER_BIT = 14;
  localparam int BCAST_BIT = 13;
  localparam int PH_HI     = 12;
  localparam int PH_LO     = 11;
  localparam int WAVE_HI   = 10;
  localparam int WAVE_LO   = 8;
  localparam int LOG_BIT   = 7;
  localparam int STEP_HI   = 6;
  localparam int STEP_LO   = 4;
  localparam int RATE_HI   = 3;
  localparam int RATE_LO   = 0;
  localparam int FALL_HI   = 3;
  localparam int FALL_LO   = 1;
  localparam int DATA_HI   = 15;
  localparam int DATA_LO   = 4;
  localparam int LOG_SHIFT = 5;
  localparam int PH_W      = 16;
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_ONE  = 12'h001;
  localparam logic [11:0] CODE_MID  = 12'h800;
  localparam logic [3:0]  RATE_JUMP = 4'h0;
  localparam logic [2:0]  WAVE_TRI  = 3'h0;
  localparam logic [2:0]  WAVE_SAW  = 3'h1;
  localparam logic [2:0]  WAVE_ISAW = 3'h2;
  localparam logic [2:0]  WAVE_SINE = 3'h4;
  localparam logic [2:0]  WAVE_OFF  = 3'h7;
  localparam logic [5:0]  STEP_LSB [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};
  localparam logic [15:0] PH_OFS [4] = '{16'h0000, 16'h5555, 16'hAAAB, 16'h4000};
  // step intervals in ns, cycle counts rounded up to whole clocks
  localparam int CLK_NS  = 100;
  localparam int T01_NS  = 4000;
  localparam int T02_NS  = 8000;
  localparam int T03_NS  = 12000;
  localparam int T04_NS  = 18000;
  localparam int T05_NS  = 27040;
  localparam int T06_NS  = 40480;
  localparam int T07_NS  = 60720;
  localparam int T08_NS  = 91120;
  localparam int T09_NS  = 136720;
  localparam int T10_NS  = 239200;
  localparam int T11_NS  = 418640;
  localparam int T12_NS  = 732560;
  localparam int T13_NS  = 1282000;
  localparam int T14_NS  = 2563960;
  localparam int T15_NS  = 5127920;
  localparam int CYC [16] = '{1,
    (T01_NS + CLK_NS - 1) / CLK_NS, (T02_NS + CLK_NS - 1) / CLK_NS, (T03_NS + CLK_NS - 1) / CLK_NS,
    (T04_NS + CLK_NS - 1) / CLK_NS, (T05_NS + CLK_NS - 1) / CLK_NS, (T06_NS + CLK_NS - 1) / CLK_NS,
    (T07_NS + CLK_NS - 1) / CLK_NS, (T08_NS + CLK_NS - 1) / CLK_NS, (T09_NS + CLK_NS - 1) / CLK_NS,
    (T10_NS + CLK_NS - 1) / CLK_NS, (T11_NS + CLK_NS - 1) / CLK_NS, (T12_NS + CLK_NS - 1) / CLK_NS,
    (T13_NS + CLK_NS - 1) / CLK_NS, (T14_NS + CLK_NS - 1) / CLK_NS, (T15_NS + CLK_NS - 1) / CLK_NS};
endpackage
`default_nettype wire

// *** design/step_timer.sv ***
// step_timer: one tick per selected step interval while running.
// assumes the index is held steady during a run.
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
  parameter int P_C11 = chan_fn_pkg::CYC[11],
  parameter int P_C12 = chan_fn_pkg::CYC[12],
  parameter int P_C13 = chan_fn_pkg::CYC[13],
  parameter int P_C14 = chan_fn_pkg::CYC[14],
  parameter int P_C15 = chan_fn_pkg::CYC[15]
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_run,
  input  wire logic [3:0] i_idx,
  output var  logic       o_tick
);
  logic [chan_fn_pkg::CNT_W-1:0] lim;
  logic [chan_fn_pkg::CNT_W-1:0] cnt_q;

  // interval table lookup, long entries overridable
  always_comb
  begin
    case (i_idx)
      4'hB:    lim = chan_fn_pkg::CNT_W'(P_C11);
      4'hC:    lim = chan_fn_pkg::CNT_W'(P_C12);
      4'hD:    lim = chan_fn_pkg::CNT_W'(P_C13);
      4'hE:    lim = chan_fn_pkg::CNT_W'(P_C14);
      4'hF:    lim = chan_fn_pkg::CNT_W'(P_C15);
      default: lim = chan_fn_pkg::CNT_W'(chan_fn_pkg::CYC[i_idx]);
    endcase
  end

  // interval counter
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end
    else if (!i_run || cnt_q >= lim - 1'b1)
    begin
      cnt_q  <= '0;
      o_tick <= i_run;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** sim/chan_host_model.sv ***
// chan_host_model: host side of one channel, drives strobes, margins and load pins.
// assumes the bench calls its tasks; every change lands on a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module chan_host_model (
  input  wire logic        i_core_clk,
  output var  logic        o_setup_wr,
  output var  logic        o_code_wr,
  output var  logic        o_bcast_wr,
  output var  logic [15:0] o_wdata,
  output var  logic        o_load_strobe,
  output var  logic        o_load_trig,
  output var  logic        o_clear,
  output var  logic [11:0] o_margin_high,
  output var  logic [11:0] o_margin_low,
  output var  logic        o_go_high,
  output var  logic        o_go_low,
  output var  logic        o_wave_en
);
  ////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial
  begin
    {o_setup_wr, o_code_wr, o_bcast_wr, o_load_trig, o_clear} = 5'h00;
    {o_go_high, o_go_low, o_wave_en} = 3'h0;
    o_load_strobe = 1'b1;
    o_wdata = 16'h0000;
    o_margin_high = 12'h000;
    o_margin_low = 12'h000;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle pulse of a strobe, k picks which
  task automatic pulse(input int k, input logic [15:0] d);
    @(negedge i_core_clk);
    o_wdata = d;
    case (k)
      0: o_setup_wr = 1'b1;
      1: o_code_wr = 1'b1;
      2: o_bcast_wr = 1'b1;
      3: o_load_trig = 1'b1;
      4: o_clear = 1'b1;
      5: o_go_high = 1'b1;
      6: o_go_low = 1'b1;
      default: o_load_strobe = 1'b0; // falling edge of load_strobe
    endcase
    @(negedge i_core_clk);
    {o_setup_wr, o_code_wr, o_bcast_wr, o_load_trig, o_clear, o_go_high, o_go_low} = 7'h00;
    o_load_strobe = 1'b1;
    o_wdata = ~d; // stale data never lingers
  endtask
  // margin bound levels, held until the next call
  task automatic margins(input logic [11:0] hi, input logic [11:0] lo);
    @(negedge i_core_clk);
    o_margin_high = hi;
    o_margin_low = lo;
  endtask
  // wave enable only with a nonzero interval code
  task automatic wave(input logic en);
    @(negedge i_core_clk);
    o_wave_en = en;
  endtask
endmodule
`default_nettype wire

// *** sim/chan_func_ctrl_bench.sv ***
// chan_func_ctrl_bench: self-checking bench for the channel function sequencer.
// assumes a 10 MHz clock and the host model for every design input except the reset.
`timescale 1ns/1ps
`default_nettype none
module chan_func_ctrl_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  wire         setup_wr, code_wr, bcast_wr, load_strobe, load_trig, clear;
  wire         go_high, go_low, wave_en;
  wire  [15:0] wdata;
  wire  [11:0] margin_high, margin_low;
  logic [15:0] setup_q;
  logic [11:0] code_q;
  logic        slewing;
  int          miscompares = 0;
  int          compares = 0;
  int          gap;
  typedef struct { logic [15:0] setup; int kind; logic [15:0] d; logic [11:0] code; } row_s;
  row_s rows [5] = '{'{16'h0000, 1, 16'hABC5, 12'hABC}, '{16'h0000, 2, 16'h1230, 12'hABC},
                     '{16'h2000, 2, 16'h1230, 12'h123}, '{16'h0000, 4, 16'h0000, 12'h000},
                     '{16'h8000, 4, 16'h0000, 12'h800}};
  ////////////////////////////////////////////////////////////////
  // clock and units
  always #50 clk = ~clk;
  chan_host_model i_chan_host_model (.i_core_clk(clk), .o_setup_wr(setup_wr), .o_code_wr(code_wr),
    .o_bcast_wr(bcast_wr), .o_wdata(wdata), .o_load_strobe(load_strobe), .o_load_trig(load_trig),
    .o_clear(clear), .o_margin_high(margin_high), .o_margin_low(margin_low), .o_go_high(go_high),
    .o_go_low(go_low), .o_wave_en(wave_en));
  chan_func_ctrl i_chan_func_ctrl (
    .i_core_clk(clk), .i_rstn(rstn), .i_setup_wr(setup_wr), .i_code_wr(code_wr), .i_bcast_wr(bcast_wr),
    .i_wdata(wdata), .i_load_strobe(load_strobe), .i_load_trig(load_trig), .i_clear(clear),
    .i_margin_high(margin_high), .i_margin_low(margin_low), .i_go_high(go_high), .i_go_low(go_low),
    .i_wave_en(wave_en), .o_setup_q(setup_q), .o_code_q(code_q), .o_slewing(slewing));
  ////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // cycles until the code moves, bounded
  task automatic wait_change(input int lim, output int n);
    logic [11:0] old;
    old = code_q;
    n = 0;
    while (code_q === old)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
      begin
        check("code change", 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
  endtask
  // wait for a slew to finish, bounded
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (slewing !== 1'b0)
    begin
      @(negedge clk);
      n++;
      if (n > 20000)
      begin
        check("slew end", 16'h0000, 16'h0001);
        tally_and_finish();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    check("reset setup", 16'h0000, setup_q);
    check("reset code", 16'h0000, {4'h0, code_q});
    check("reset slewing", 16'h0000, {15'h0000, slewing});
    rstn = 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      i_chan_host_model.pulse(0, rows[i].setup);
      check("setup readback", rows[i].setup, setup_q);
      i_chan_host_model.pulse(rows[i].kind, rows[i].d);
      check("row code", {4'h0, rows[i].code}, {4'h0, code_q});
    end
    $display("test rows done");
    // linear slew, 32 LSB step, 40 cycle interval, clamped at 100
    i_chan_host_model.pulse(0, 16'h0071);
    i_chan_host_model.pulse(4, 16'h0000);
    i_chan_host_model.margins(12'h064, 12'h000);
    i_chan_host_model.pulse(5, 16'h0000);
    wait_change(200, gap);
    check("linear first step", 16'h0020, {4'h0, code_q});
    check("slewing flag", 16'h0001, {15'h0000, slewing});
    wait_change(200, gap);
    check("linear interval", 16'h0028, gap[15:0]);
    wait_idle();
    check("linear clamp", 16'h0064, {4'h0, code_q});
    // interval code 0000 jumps
    i_chan_host_model.pulse(0, 16'h0070);
    i_chan_host_model.pulse(6, 16'h0000);
    check("jump low", 16'h0000, {4'h0, code_q});
    $display("test linear done");
    // logarithmic slew: rise idx 1, fall idx 3
    i_chan_host_model.pulse(0, 16'h0082);
    i_chan_host_model.margins(12'h040, 12'h000);
    i_chan_host_model.pulse(5, 16'h0000);
    check("log start", 16'h0001, {4'h0, code_q});
    wait_change(200, gap);
    wait_change(200, gap);
    check("log rise interval", 16'h0028, gap[15:0]);
    wait_idle();
    check("log top", 16'h0040, {4'h0, code_q});
    i_chan_host_model.pulse(6, 16'h0000);
    wait_change(400, gap);
    check("log first fall", 16'h003E, {4'h0, code_q});
    wait_change(400, gap);
    check("log fall interval", 16'h0078, gap[15:0]);
    wait_idle();
    check("log bottom", 16'h0000, {4'h0, code_q});
    $display("test log done");
    // deferred update by trigger, then by strobe fall
    i_chan_host_model.pulse(0, 16'h4000);
    i_chan_host_model.pulse(1, 16'h5550);
    check("deferred hold", 16'h0000, {4'h0, code_q});
    i_chan_host_model.pulse(3, 16'h0000);
    check("trigger load", 16'h0555, {4'h0, code_q});
    i_chan_host_model.pulse(1, 16'h7770);
    i_chan_host_model.pulse(7, 16'h0000);
    check("strobe load", 16'h0777, {4'h0, code_q});
    $display("test deferred done");
    // sawtooth generation moves the code
    i_chan_host_model.pulse(0, 16'h0901);
    i_chan_host_model.wave(1'b1);
    wait_change(400, gap);
    check("wave first code", 16'h0015, {4'h0, code_q});
    i_chan_host_model.wave(1'b0);
    $display("test wave done");
    // reset again once the wave has stopped, with a nonzero setup, then an immediate write
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    check("rerun setup", 16'h0000, setup_q);
    check("rerun code", 16'h0000, {4'h0, code_q});
    rstn = 1'b1;
    i_chan_host_model.pulse(1, 16'h9990);
    check("write after rerun", 16'h0999, {4'h0, code_q});
    $display("test reset again done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
